//--- nlm_defs.svh
// Purpose: constants of the link and interrupt-message register bank
// Assumes: byte address of a register is four times its word index
// Notes: indices are kept as printed because some are not multiples of four
// Operation
// - max speed reads fixed 0x1
// - max width reads fixed 0x8
// - power support reads 0x01, never used
// - shallow exit latency reads zero
// - deep exit latency reads zero
// - port index reads zero
// - power control writable, resets zero
// - completion boundary bit reads zero
// - link off and retrain bits read zero
// - clock and sync bits stored only
// - current speed 0x1, current width 0x8
// - training and slot clock bits zero
// - capability id 0x5, next 0x74
// - message enable writable, resets zero
// - multi message fields read zero
// - wide address capable reads one
// - lower address bits 31:2 stored
// - nonzero upper address selects wide write
// - payload gives low 16 data bits
// - vendor header resets 0x9 and 0xB4
`ifndef NLM_DEFS_SVH
`define NLM_DEFS_SVH

`define NLM_IDX_LCAP      10'h04c
`define NLM_IDX_LCTL      10'h050
`define NLM_IDX_LSTS      10'h052
`define NLM_IDX_MSICAP    10'h064
`define NLM_IDX_MADDR     10'h068
`define NLM_IDX_MUADDR    10'h06c
`define NLM_IDX_PAYLOAD   10'h070
`define NLM_IDX_VCAP      10'h074

`define NLM_MAX_SPEED     4'h1
`define NLM_MAX_WIDTH     6'h08
`define NLM_PM_SUPPORT    2'h1
`define NLM_L0S_LAT       3'h0
`define NLM_L1_LAT        3'h0
`define NLM_PORT_IDX      8'h00
`define NLM_CAP_ID        8'h05
`define NLM_CAP_NEXT      8'h74
`define NLM_MMC           3'h0
`define NLM_MULTI_MSG_EN  3'h0
`define NLM_WIDE_CAP      1'h1
`define NLM_PM_CTL_RST    2'h0
`define NLM_VCAP_ID_RST   8'h09
`define NLM_VCAP_NXT_RST  8'hb4
`define NLM_MSI_EN_BIT    16
`define NLM_SHARED_CLK_BIT 6
`define NLM_EXT_SYNC_BIT   7

`endif

//--- nlm_pkg.sv
// Purpose: types shared by the register bank and its users
// Assumes: nothing
// Notes: none
package nlm_pkg;

  typedef struct packed {
    logic        wide;
    logic [63:0] addr;
    logic [31:0] data;
  } nlm_msi_wr_t;

  typedef struct packed {
    logic       ext_sync;
    logic       shared_clk;
    logic [1:0] pm_ctl;
  } nlm_link_ctl_t;

  typedef enum logic [1:0] {
    NLM_IDLE = 2'b01,
    NLM_SEND = 2'b10
  } nlm_msi_st_t;

endpackage

//--- nlm_regs.sv
// Purpose: link capability/control/status, message interrupt and vendor header registers
// Assumes: APB master with setup then access phase; inputs synchronous to clk_i
// Notes: one wait-free access phase; events while disabled are dropped
`timescale 1ns/1ps
`default_nettype none
`include "nlm_defs.svh"

module nlm_regs #(
  parameter int ADDR_W = 12
) (
  input  wire logic               clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [ADDR_W-1:0]  paddr_i,
  input  wire logic [31:0]        pwdata_i,
  input  wire logic [3:0]         pstrb_i,
  output logic [31:0]             prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic               msi_event_i,
  input  wire logic               msi_ready_i,
  output logic                    msi_valid_o,
  output nlm_pkg::nlm_msi_wr_t    msi_wr_o,
  output logic                    msi_enable_o
);

  generate
    if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr_w
      $error("nlm_regs: ADDR_W must lie in 9..32");
    end
  endgenerate

  localparam int IW = ADDR_W - 2;

  logic [IW-1:0]           widx;
  logic                    setup;
  logic                    fin;
  logic                    wr_en;
  logic [3:0]              wr_b;
  logic                    hit;
  logic [31:0]             rd_mux;

  logic [31:0]             prdata_r;
  logic                    pready_r;
  logic                    pslverr_r;

  nlm_pkg::nlm_link_ctl_t  lctl_r;
  logic                    msi_en_r;
  logic [29:0]             addr_lo_r;
  logic [31:0]             addr_hi_r;
  logic [15:0]             payload_r;
  logic [7:0]              vcap_id_r;
  logic [7:0]              vcap_nxt_r;

  nlm_pkg::nlm_msi_st_t    st_r;
  logic                    pend_r;
  logic                    pend_nxt;
  logic                    launch;
  logic                    msi_valid_r;
  nlm_pkg::nlm_msi_wr_t    msi_wr_r;

  logic [31:0]             lcap_val;
  logic [31:0]             lctl_val;
  logic [31:0]             lsts_val;
  logic [31:0]             msicap_val;
  logic [31:0]             maddr_val;
  logic [31:0]             payload_val;
  logic [31:0]             vcap_val;

  assign widx  = paddr_i[ADDR_W-1:2];
  assign setup = psel_i & ~penable_i;
  assign fin   = psel_i & penable_i & pready_r;
  assign wr_en = fin & pwrite_i & ~pslverr_r;
  assign wr_b  = pstrb_i & {4{wr_en}};

  // fixed fields are built from constants only, so writes cannot reach them
  assign lcap_val = {`NLM_PORT_IDX,
                     6'h00,
                     `NLM_L1_LAT,
                     `NLM_L0S_LAT,
                     `NLM_PM_SUPPORT,
                     `NLM_MAX_WIDTH,
                     `NLM_MAX_SPEED};

  assign lctl_val = {16'h0000,
                     8'h00,
                     lctl_r.ext_sync,
                     lctl_r.shared_clk,
                     1'b0,
                     1'b0,
                     1'b0,
                     1'b0,
                     lctl_r.pm_ctl};

  assign lsts_val = {16'h0000,
                     3'h0,
                     3'h0,
                     `NLM_MAX_WIDTH,
                     `NLM_MAX_SPEED};

  assign msicap_val = {8'h00,
                       `NLM_WIDE_CAP,
                       `NLM_MULTI_MSG_EN,
                       `NLM_MMC,
                       msi_en_r,
                       `NLM_CAP_NEXT,
                       `NLM_CAP_ID};

  assign maddr_val   = {addr_lo_r, 2'b00};
  assign payload_val = {16'h0000, payload_r};
  assign vcap_val    = {16'h0000, vcap_nxt_r, vcap_id_r};

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    case (widx)
      IW'(`NLM_IDX_LCAP):   rd_mux = lcap_val;
      IW'(`NLM_IDX_LCTL):   rd_mux = lctl_val;
      IW'(`NLM_IDX_LSTS):   rd_mux = lsts_val;
      IW'(`NLM_IDX_MSICAP): rd_mux = msicap_val;
      IW'(`NLM_IDX_MADDR):  rd_mux = maddr_val;
      IW'(`NLM_IDX_MUADDR): rd_mux = addr_hi_r;
      IW'(`NLM_IDX_PAYLOAD): rd_mux = payload_val;
      IW'(`NLM_IDX_VCAP):   rd_mux = vcap_val;
      default:              hit = 1'b0;
    endcase
  end

  // ready rises in the first access cycle and drops at completion,
  // so back-to-back transfers each see a fresh setup decode
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup;
      if (setup) begin
        pslverr_r <= ~hit;
        prdata_r  <= pwrite_i ? 32'h0000_0000 : rd_mux;
      end else if (fin) begin
        pslverr_r <= 1'b0;
        prdata_r  <= 32'h0000_0000;
      end
    end
  end

  // power control and the two link bits are plain storage; nothing acts on them
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lctl_r.pm_ctl <= `NLM_PM_CTL_RST;
      lctl_r.shared_clk <= 1'b0;
      lctl_r.ext_sync   <= 1'b0;
    end else if (widx == IW'(`NLM_IDX_LCTL) && wr_b[0]) begin
      lctl_r.pm_ctl <= pwdata_i[1:0];
      lctl_r.shared_clk <= pwdata_i[`NLM_SHARED_CLK_BIT];
      lctl_r.ext_sync   <= pwdata_i[`NLM_EXT_SYNC_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      msi_en_r <= 1'b0;
    end else if (widx == IW'(`NLM_IDX_MSICAP) && wr_b[2]) begin
      msi_en_r <= pwdata_i[`NLM_MSI_EN_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_lo_r <= 30'h0000_0000;
    end else if (widx == IW'(`NLM_IDX_MADDR)) begin
      if (wr_b[0]) addr_lo_r[5:0]   <= pwdata_i[7:2];
      if (wr_b[1]) addr_lo_r[13:6]  <= pwdata_i[15:8];
      if (wr_b[2]) addr_lo_r[21:14] <= pwdata_i[23:16];
      if (wr_b[3]) addr_lo_r[29:22] <= pwdata_i[31:24];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_hi_r <= 32'h0000_0000;
    end else if (widx == IW'(`NLM_IDX_MUADDR)) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_b[b]) addr_hi_r[b*8 +: 8] <= pwdata_i[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      payload_r <= 16'h0000;
    end else if (widx == IW'(`NLM_IDX_PAYLOAD)) begin
      if (wr_b[0]) payload_r[7:0]  <= pwdata_i[7:0];
      if (wr_b[1]) payload_r[15:8] <= pwdata_i[15:8];
    end
  end

  // header fields take writes for test use only; software must leave them alone
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      vcap_id_r  <= `NLM_VCAP_ID_RST;
      vcap_nxt_r <= `NLM_VCAP_NXT_RST;
    end else if (widx == IW'(`NLM_IDX_VCAP)) begin
      if (wr_b[0]) vcap_id_r  <= pwdata_i[7:0];
      if (wr_b[1]) vcap_nxt_r <= pwdata_i[15:8];
    end
  end

  // an event in the launch cycle re-arms the pending flag: set wins
  assign launch   = (st_r == nlm_pkg::NLM_IDLE) & pend_r & msi_en_r;
  assign pend_nxt = (pend_r & ~launch) | (msi_event_i & msi_en_r);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // a posted request is finished even if software disables meanwhile
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r        <= nlm_pkg::NLM_IDLE;
      msi_valid_r <= 1'b0;
      msi_wr_r    <= '0;
    end else begin
      case (st_r)
        nlm_pkg::NLM_IDLE: begin
          if (launch) begin
            msi_valid_r   <= 1'b1;
            msi_wr_r.wide <= (addr_hi_r != 32'h0000_0000);
            msi_wr_r.addr <= {addr_hi_r, addr_lo_r, 2'b00};
            msi_wr_r.data <= {16'h0000, payload_r};
            st_r          <= nlm_pkg::NLM_SEND;
          end
        end
        nlm_pkg::NLM_SEND: begin
          if (msi_ready_i) begin
            msi_valid_r <= 1'b0;
            st_r        <= nlm_pkg::NLM_IDLE;
          end
        end
        default: begin
          msi_valid_r <= 1'b0;
          st_r        <= nlm_pkg::NLM_IDLE;
        end
      endcase
    end
  end

  assign prdata_o     = prdata_r;
  assign pready_o     = pready_r;
  assign pslverr_o    = pslverr_r;
  assign msi_valid_o  = msi_valid_r;
  assign msi_wr_o     = msi_wr_r;
  assign msi_enable_o = msi_en_r;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  logic rd_fin;
  assign rd_fin = fin & ~pwrite_i;

  property p_lcap_speed;
    rd_fin && widx == IW'(`NLM_IDX_LCAP) |-> prdata_o[3:0] == 4'h1;
  endproperty
  a_lcap_speed: assert property (p_lcap_speed)
    else $error("link speed field not 0x1");

  property p_lcap_width;
    rd_fin && widx == IW'(`NLM_IDX_LCAP) |-> prdata_o[9:4] == 6'h08;
  endproperty
  a_lcap_width: assert property (p_lcap_width)
    else $error("link width field not 0x8");

  property p_lcap_rest;
    rd_fin && widx == IW'(`NLM_IDX_LCAP) |-> prdata_o[31:10] == 22'h00_0001;
  endproperty
  a_lcap_rest: assert property (p_lcap_rest)
    else $error("link capability upper fields wrong");

  property p_lctl_fixed;
    rd_fin && widx == IW'(`NLM_IDX_LCTL) |-> prdata_o[5:2] == 4'h0 && prdata_o[31:8] == 24'h0;
  endproperty
  a_lctl_fixed: assert property (p_lctl_fixed)
    else $error("link control fixed bits not zero");

  property p_lctl_store;
    wr_en && widx == IW'(`NLM_IDX_LCTL) && pstrb_i[0] |=> lctl_r.pm_ctl == $past(pwdata_i[1:0]);
  endproperty
  a_lctl_store: assert property (p_lctl_store)
    else $error("power control write lost");

  property p_lsts;
    rd_fin && widx == IW'(`NLM_IDX_LSTS) |-> prdata_o == 32'h0000_0081;
  endproperty
  a_lsts: assert property (p_lsts)
    else $error("link status value wrong");

  property p_msicap;
    rd_fin && widx == IW'(`NLM_IDX_MSICAP) |->
      prdata_o[15:0] == 16'h7405 && prdata_o[31:17] == 15'h0040;
  endproperty
  a_msicap: assert property (p_msicap)
    else $error("message capability fixed fields wrong");

  property p_en_write;
    wr_en && widx == IW'(`NLM_IDX_MSICAP) && pstrb_i[2] |=> ##1 msi_enable_o == $past(pwdata_i[16], 2);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("message enable write lost");

  property p_addr_low;
    rd_fin && widx == IW'(`NLM_IDX_MADDR) |-> prdata_o[1:0] == 2'b00;
  endproperty
  a_addr_low: assert property (p_addr_low)
    else $error("lower address bits 1:0 not zero");

  property p_wide_sel;
    msi_valid_o |-> msi_wr_o.wide == (msi_wr_o.addr[63:32] != 32'h0000_0000);
  endproperty
  a_wide_sel: assert property (p_wide_sel)
    else $error("wide flag disagrees with upper address");

  property p_send_gate;
    $rose(msi_valid_o) |-> $past(msi_en_r) && msi_wr_o.data[31:16] == 16'h0000;
  endproperty
  a_send_gate: assert property (p_send_gate)
    else $error("message sent while disabled or upper data set");

  property p_hold;
    msi_valid_o && !msi_ready_i |=> msi_valid_o && $stable(msi_wr_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("message request dropped or changed before ready");

  property p_ready;
    setup |=> pready_o ##1 !pready_o || setup;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready not given in first access cycle");

  property p_lctl_bits;
    wr_en && widx == IW'(`NLM_IDX_LCTL) && pstrb_i[0] |=>
      lctl_r.shared_clk == $past(pwdata_i[`NLM_SHARED_CLK_BIT]) &&
      lctl_r.ext_sync == $past(pwdata_i[`NLM_EXT_SYNC_BIT]);
  endproperty
  a_lctl_bits: assert property (p_lctl_bits)
    else $error("clock or sync bit write lost");

  property p_payload_hi;
    rd_fin && widx == IW'(`NLM_IDX_PAYLOAD) |-> prdata_o[31:16] == 16'h0000;
  endproperty
  a_payload_hi: assert property (p_payload_hi)
    else $error("payload upper bits not zero");

  property p_vcap_hi;
    rd_fin && widx == IW'(`NLM_IDX_VCAP) |-> prdata_o[31:16] == 16'h0000;
  endproperty
  a_vcap_hi: assert property (p_vcap_hi)
    else $error("vendor header upper bits not zero");

  // unmapped words answer with an error and an all-zero word
  property p_unmapped;
    fin && !hit |-> pslverr_o && prdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  c_msi_sent:   cover property ($rose(msi_valid_o) ##[1:8] !msi_valid_o);
  c_wide_sent:  cover property ($rose(msi_valid_o) && msi_wr_o.wide);
  c_bad_addr:   cover property (fin && pslverr_o);
  c_ev_launch:  cover property (launch && msi_event_i);

endmodule

`default_nettype wire

//--- nlm_msi_sink.sv
// Purpose: host-side sink that accepts interrupt message writes
// Assumes: request holds valid and payload until ready is seen high
// Notes: stall_i plus one is how many cycles the host lets a request wait
`timescale 1ns/1ps
`default_nettype none

module nlm_msi_sink (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  msi_valid_i,
  input  wire nlm_pkg::nlm_msi_wr_t  msi_wr_i,
  input  wire logic [3:0]            stall_i,
  output logic                       msi_ready_o,
  output logic [7:0]                 count_o,
  output nlm_pkg::nlm_msi_wr_t       last_o
);
  logic [3:0] wait_r;

  // ready is a one-cycle pulse so a stuck valid shows up as a second accept
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_r      <= 4'h0;
      msi_ready_o <= 1'b0;
    end else begin
      msi_ready_o <= 1'b0;
      if (msi_valid_i && !msi_ready_o) begin
        if (wait_r == stall_i) begin
          msi_ready_o <= 1'b1;
          wait_r      <= 4'h0;
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_o <= 8'h00;
      last_o  <= '0;
    end else if (msi_valid_i && msi_ready_o) begin
      count_o <= count_o + 8'h01;
      last_o  <= msi_wr_i;
    end
  end
endmodule

`default_nettype wire

//--- nlm_regs_tb.sv
// Purpose: self-checking bench for the link and message-interrupt register bank
// Assumes: apb slave answers in its own time; sink model accepts message writes
// Notes: expected words are written from field values, never read back first
`timescale 1ns/1ps
`default_nettype none
`include "nlm_defs.svh"

module nlm_regs_tb;
  logic                 clk_i;
  logic                 sys_rst_i;
  logic                 psel_i;
  logic                 penable_i;
  logic                 pwrite_i;
  logic [11:0]          paddr_i;
  logic [31:0]          pwdata_i;
  logic [3:0]           pstrb_i;
  logic [31:0]          prdata_o;
  logic                 pready_o;
  logic                 pslverr_o;
  logic                 msi_event_i;
  logic                 msi_ready;
  logic                 msi_valid_o;
  nlm_pkg::nlm_msi_wr_t msi_wr_o;
  nlm_pkg::nlm_msi_wr_t last_wr;
  logic                 msi_enable_o;
  logic [3:0]           stall;
  logic [7:0]           msg_cnt;
  logic [11:0]          adr [8];
  logic [31:0]          rst_exp [8];
  logic [31:0]          ones_exp [8];
  logic [31:0]          rd;
  logic                 err;
  int                   num_errors;
  int                   total_checks;

  nlm_regs #(.ADDR_W(12)) u_nlm_regs (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .msi_event_i(msi_event_i), .msi_ready_i(msi_ready), .msi_valid_o(msi_valid_o),
    .msi_wr_o(msi_wr_o), .msi_enable_o(msi_enable_o));

  nlm_msi_sink u_nlm_msi_sink (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .msi_valid_i(msi_valid_o), .msi_wr_i(msi_wr_o),
    .stall_i(stall), .msi_ready_o(msi_ready), .count_o(msg_cnt), .last_o(last_wr));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkwr(input nlm_pkg::nlm_msi_wr_t got, input nlm_pkg::nlm_msi_wr_t exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // setup, access, then hold until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    pstrb_i   <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      wrap_up();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic t_reset_values();
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, adr[i], 32'h0000_0000, 4'hf);
      chk32(rd, rst_exp[i]);
    end
    chk32({31'h0, msi_enable_o}, 32'h0000_0000);
    $display("reset values done");
  endtask

  // the vendor header is written here only as a test-time access
  task automatic t_write_ones();
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, adr[i], 32'hffff_ffff, 4'hf);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, adr[i], 32'h0000_0000, 4'hf);
      chk32(rd, ones_exp[i]);
    end
    chk32({31'h0, msi_enable_o}, 32'h0000_0001);
    apb(1'b1, adr[4], 32'h0000_0000, 4'h1);
    apb(1'b0, adr[4], 32'h0000_0000, 4'hf);
    chk32(rd, 32'hffff_ff00);
    apb(1'b1, 12'h144, 32'hffff_ffff, 4'hf);
    chk32({31'h0, err}, 32'h0000_0001);
    apb(1'b0, 12'h144, 32'h0000_0000, 4'hf);
    chk32(rd, 32'h0000_0000);
    $display("write ones done");
  endtask

  task automatic fire(input logic [3:0] s, input nlm_pkg::nlm_msi_wr_t exp);
    logic [7:0] c0;
    int n;
    c0 = msg_cnt;
    stall <= s;
    @(posedge clk_i);
    msi_event_i <= 1'b1;
    @(posedge clk_i);
    msi_event_i <= 1'b0;
    n = 0;
    while (msg_cnt === c0 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (msg_cnt === c0) begin
      num_errors++;
      wrap_up();
    end
    chk32({24'h0, msg_cnt}, {24'h0, c0 + 8'h01});
    chkwr(last_wr, exp);
  endtask

  task automatic t_msi();
    logic [7:0] c0;
    c0 = msg_cnt;
    @(posedge clk_i);
    msi_event_i <= 1'b1;
    @(posedge clk_i);
    msi_event_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk32({24'h0, msg_cnt}, {24'h0, c0});
    apb(1'b1, adr[3], 32'h0001_0000, 4'hf);
    apb(1'b1, adr[4], 32'h1234_5677, 4'hf);
    apb(1'b1, adr[6], 32'habcd_1234, 4'hf);
    fire(4'h3, {1'b0, 32'h0000_0000, 32'h1234_5674, 32'h0000_1234});
    apb(1'b1, adr[5], 32'h0000_00a5, 4'hf);
    fire(4'h0, {1'b1, 32'h0000_00a5, 32'h1234_5674, 32'h0000_1234});
    $display("message interrupt done");
  endtask

  // events held across the launch and the posted message fold into one more message
  task automatic t_fold();
    logic [7:0] c0;
    int n;
    c0 = msg_cnt;
    stall <= 4'h2;
    @(posedge clk_i);
    msi_event_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    msi_event_i <= 1'b0;
    n = 0;
    while (msg_cnt !== c0 + 8'h02 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 60) begin
      num_errors++;
      wrap_up();
    end
    repeat (20) @(posedge clk_i);
    chk32({24'h0, msg_cnt}, {24'h0, c0 + 8'h02});
    $display("event fold done");
  endtask

  initial begin
    sys_rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0000_0000;
    pstrb_i = 4'hf;
    msi_event_i = 1'b0;
    stall = 4'h0;
    num_errors = 0;
    total_checks = 0;
    adr = '{{`NLM_IDX_LCAP, 2'b00}, {`NLM_IDX_LCTL, 2'b00}, {`NLM_IDX_LSTS, 2'b00},
            {`NLM_IDX_MSICAP, 2'b00}, {`NLM_IDX_MADDR, 2'b00}, {`NLM_IDX_MUADDR, 2'b00},
            {`NLM_IDX_PAYLOAD, 2'b00}, {`NLM_IDX_VCAP, 2'b00}};
    rst_exp = '{32'h0000_0481, 32'h0000_0000, 32'h0000_0081, 32'h0080_7405,
                32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_b409};
    ones_exp = '{32'h0000_0481, 32'h0000_00c3, 32'h0000_0081, 32'h0081_7405,
                 32'hffff_fffc, 32'hffff_ffff, 32'h0000_ffff, 32'h0000_ffff};
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset_values();
    t_write_ones();
    // a second reset in mid-run must bring every stored field back
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset_values();
    t_msi();
    t_fold();
    wrap_up();
  end
endmodule

`default_nettype wire
